// File: pkg/mqrp_pkg.sv
// Package for the multi-queue read port select block
package mqrp_pkg;
  localparam int unsigned NUM_QUEUES = 32;
  localparam int unsigned QUEUE_W = 5;
  localparam int unsigned DEV_W = 3;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned QUAD_W = 2;
  localparam int unsigned FLAG_BUS_W = 8;
  localparam int unsigned DATA_W = 36;
  localparam int unsigned DEPTH_W = 4;
  localparam int unsigned DEPTH = 16;
  localparam int unsigned AE_LEVEL = 2;
  localparam int unsigned QUEUE_LSB = 0;
  localparam int unsigned DEV_LSB = 5;
  localparam int unsigned QUAD_LSB = 0;
  localparam int unsigned DEV_ID_W = 3;
  // APB register offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_IRQ_STAT = 12'h008;
  localparam logic [11:0] REG_IRQ_MASK = 12'h00C;
  localparam logic [11:0] REG_SEL = 12'h010;
  localparam logic [11:0] REG_WDATA = 12'h014;
  // Control field positions
  localparam int unsigned CTRL_POLLED = 0;
  localparam int unsigned CTRL_DEVID_LSB = 1;
  localparam int unsigned CTRL_EXP_EN = 4;
  localparam int unsigned CTRL_PROG_DONE = 5;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Interrupt bits
  localparam int unsigned IRQ_QSEL = 0;
  localparam int unsigned IRQ_FSEL = 1;
  localparam int unsigned IRQ_CLASH = 2;
  localparam int unsigned IRQ_EARLY = 3;
  localparam int unsigned IRQ_W = 4;

  typedef struct packed {
    logic queue_sel_strobe;
    logic flag_quad_strobe;
    logic read_en;
    logic [ADDR_W-1:0] read_addr_bus;
  } mqrp_req_s;

  typedef struct packed {
    logic [FLAG_BUS_W-1:0] almost_empty_flag_bus;
    logic [FLAG_BUS_W-1:0] packet_ready_flag_bus;
    logic flag_cycle_sync;
  } mqrp_flag_s;

  typedef enum logic [1:0] {
    MQRP_IDLE,
    MQRP_FALL,
    MQRP_RUN
  } mqrp_state_e;
endpackage : mqrp_pkg

// File: logic/mqrp_top.sv
// Read-port queue and flag quadrant selection of a multi-queue FIFO
`timescale 1ns/10ps
// Behaviour
// RQ1 - Read one word per edge under enable
// RQ2 - Queue select captured on strobed edge
// RQ3 - Low five address bits pick queue
// RQ4 - Top three bits must match device id
// RQ5 - New queue word appears second cycle
// RQ6 - Select edge may still output old word
// RQ7 - Queue select ignores read enable
// RQ8 - Two low bits pick flag quadrant
// RQ9 - Flag quadrant captured on flag strobe
// RQ10 - Polled mode steps quadrants with sync
// RQ11 - Single flags updated on read clock
// RQ12 - Expansion handshake timed by read clock
// RQ13 - Controller keeps read clock running
// RQ14 - Flag bus needs no read enable
// RQ15 - Never both strobes same cycle
// RQ16 - No queue select before programming done
// RQ17 - Queue strobe only during changes
// RQ18 - Selections held until next capture
module mqrp_top
  import mqrp_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire mqrp_req_s req_i,
  input wire logic expansion_in_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic [DATA_W-1:0] rdata_o,
  output logic output_valid_flag_o,
  output logic almost_empty_flag_o,
  output logic packet_ready_flag_o,
  output mqrp_flag_s flags_o,
  output logic expansion_out_o,
  output logic prog_done_out_o,
  output logic irq_o
);
  logic [DATA_W-1:0] mem_q [NUM_QUEUES][DEPTH];
  logic [DEPTH_W:0] wr_ptr_q [NUM_QUEUES];
  logic [DEPTH_W:0] rd_ptr_q [NUM_QUEUES];
  logic [QUEUE_W-1:0] cur_q_q;
  logic [QUAD_W-1:0] quad_q;
  logic [QUAD_W-1:0] poll_q;
  mqrp_state_e state_q;
  logic [31:0] ctrl_q;
  logic [QUEUE_W-1:0] wsel_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [NUM_QUEUES-1:0] empty_w;
  logic [NUM_QUEUES-1:0] aempty_w;
  logic [NUM_QUEUES-1:0] pready_w;
  logic [DEV_ID_W-1:0] dev_id_w;
  logic me_w;
  logic qsel_w;
  logic fsel_w;
  logic pop_w;
  logic apb_wr_w;
  logic apb_push_w;
  logic [IRQ_W-1:0] irq_ev_w;
  logic [QUAD_W-1:0] quad_view_w;
  logic [QUEUE_W-1:0] qbase_w;
  logic push_ok_w;
  logic rd_adv_w;
  logic show_w;
  logic [DATA_W-1:0] head_w;
  logic apb_setup_w;
  logic [IRQ_W-1:0] irq_clr_w;

  assign dev_id_w = ctrl_q[CTRL_DEVID_LSB +: DEV_ID_W];
  assign me_w = req_i.read_addr_bus[DEV_LSB +: DEV_W] == dev_id_w; // RQ4
  assign qsel_w = req_i.queue_sel_strobe && me_w && !req_i.flag_quad_strobe; // RQ2 RQ7 RQ15
  assign fsel_w = req_i.flag_quad_strobe && me_w && !req_i.queue_sel_strobe; // RQ9 RQ14
  assign apb_wr_w = psel_i && penable_i && pwrite_i;
  assign apb_push_w = apb_wr_w && paddr_i == REG_WDATA;
  assign apb_setup_w = psel_i && !penable_i;
  // Full queue drops the pushed word
  assign push_ok_w = apb_push_w && wr_ptr_q[wsel_q] - rd_ptr_q[wsel_q] != (DEPTH_W+1)'(DEPTH);

  always_comb begin
    for (int i = 0; i < NUM_QUEUES; i++) begin
      logic [DEPTH_W:0] lvl;
      lvl = wr_ptr_q[i] - rd_ptr_q[i];
      empty_w[i] = lvl == '0;
      aempty_w[i] = lvl <= (DEPTH_W+1)'(AE_LEVEL);
      pready_w[i] = lvl >= (DEPTH_W+1)'(AE_LEVEL + 1);
    end
  end

  // Pop only once the fall-through word has been shown
  assign pop_w = req_i.read_en && state_q == MQRP_RUN && !empty_w[cur_q_q] && !qsel_w; // RQ1
  assign head_w = mem_q[cur_q_q][rd_ptr_q[cur_q_q][DEPTH_W-1:0]];

  // Output loads on fall-through, pop, or select-edge read
  assign show_w = (state_q == MQRP_FALL && !qsel_w) || pop_w
                  || (req_i.read_en && qsel_w && state_q == MQRP_RUN);

  // Pointer moves only when a real word leaves
  assign rd_adv_w = show_w && !empty_w[cur_q_q];

  // Queue selection, held until next strobe
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cur_q_q <= '0;
    end else if (qsel_w) begin
      cur_q_q <= req_i.read_addr_bus[QUEUE_LSB +: QUEUE_W]; // RQ3 RQ18
    end
  end

  // Fall-through sequencing after a selection
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= MQRP_IDLE;
    end else begin
      unique case (state_q)
        MQRP_IDLE: begin
          if (qsel_w) begin
            state_q <= MQRP_FALL;
          end
        end
        MQRP_FALL: begin
          state_q <= qsel_w ? MQRP_FALL : MQRP_RUN; // RQ5
        end
        MQRP_RUN: begin
          if (qsel_w) begin
            state_q <= MQRP_FALL;
          end
        end
      endcase
    end
  end

  // Data output register; old queue word may leave on select edge
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= '0;
    end else if (show_w) begin
      rdata_o <= head_w; // RQ1 RQ5 RQ6
    end
  end

  // Valid flag follows the word shown
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      output_valid_flag_o <= 1'b0;
    end else if (show_w) begin
      output_valid_flag_o <= !empty_w[cur_q_q]; // RQ11
    end
  end

  // Queue storage, filled from the bus side; upper bits zero
  always_ff @(posedge clock_i) begin
    if (push_ok_w) begin
      mem_q[wsel_q][wr_ptr_q[wsel_q][DEPTH_W-1:0]] <= DATA_W'(pwdata_i);
    end
  end

  // Write pointers
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < NUM_QUEUES; i++) begin
        wr_ptr_q[i] <= '0;
      end
    end else if (push_ok_w) begin
      wr_ptr_q[wsel_q] <= wr_ptr_q[wsel_q] + 1'b1;
    end
  end

  // Read pointers
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < NUM_QUEUES; i++) begin
        rd_ptr_q[i] <= '0;
      end
    end else if (rd_adv_w) begin
      rd_ptr_q[cur_q_q] <= rd_ptr_q[cur_q_q] + 1'b1; // RQ1
    end
  end

  // Flag quadrant select, held until next strobe
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      quad_q <= '0;
    end else if (fsel_w) begin
      quad_q <= req_i.read_addr_bus[QUAD_LSB +: QUAD_W]; // RQ8 RQ18
    end
  end

  // Polling counter runs freely on the read clock
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      poll_q <= '0;
    end else begin
      poll_q <= poll_q + 1'b1; // RQ10
    end
  end

  assign quad_view_w = ctrl_q[CTRL_POLLED] ? poll_q : quad_q;
  assign qbase_w = {quad_view_w, 3'h0};

  // Flag status bus, active low per queue of the quadrant
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flags_o <= '0;
    end else begin
      flags_o.almost_empty_flag_bus <= ~aempty_w[qbase_w +: FLAG_BUS_W]; // RQ10 RQ14
      flags_o.packet_ready_flag_bus <= ~pready_w[qbase_w +: FLAG_BUS_W];
      flags_o.flag_cycle_sync <= ctrl_q[CTRL_POLLED] && poll_q == '0; // RQ10
    end
  end

  // Flags of the selected queue
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      almost_empty_flag_o <= 1'b1;
      packet_ready_flag_o <= 1'b0;
    end else begin
      almost_empty_flag_o <= !aempty_w[cur_q_q]; // RQ11
      packet_ready_flag_o <= pready_w[cur_q_q]; // RQ11
    end
  end

  // Expansion handshake
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      expansion_out_o <= 1'b0;
    end else begin
      expansion_out_o <= ctrl_q[CTRL_EXP_EN] && (expansion_in_i || pop_w); // RQ12
    end
  end

  // Programming done, low once software sets the control bit
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prog_done_out_o <= 1'b1;
    end else begin
      prog_done_out_o <= !ctrl_q[CTRL_PROG_DONE];
    end
  end

  // Interrupt events
  assign irq_ev_w[IRQ_QSEL] = qsel_w;
  assign irq_ev_w[IRQ_FSEL] = fsel_w;
  assign irq_ev_w[IRQ_CLASH] = req_i.queue_sel_strobe && req_i.flag_quad_strobe; // RQ15
  assign irq_ev_w[IRQ_EARLY] = req_i.queue_sel_strobe && prog_done_out_o; // RQ16

  // Control register
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_q <= CTRL_RESET;
    end else if (apb_wr_w && paddr_i == REG_CTRL) begin
      ctrl_q <= pwdata_i;
    end
  end

  // Fill queue index
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wsel_q <= '0;
    end else if (apb_wr_w && paddr_i == REG_SEL) begin
      wsel_q <= pwdata_i[QUEUE_W-1:0];
    end
  end

  // Interrupt mask
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_mask_q <= '0;
    end else if (apb_wr_w && paddr_i == REG_IRQ_MASK) begin
      irq_mask_q <= pwdata_i[IRQ_W-1:0];
    end
  end

  // Write-one-to-clear request
  assign irq_clr_w = (apb_wr_w && paddr_i == REG_IRQ_STAT) ? pwdata_i[IRQ_W-1:0] : '0;

  // Set wins over write-one-to-clear
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr_w) | irq_ev_w;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Answer in the access cycle right after setup
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pready_o <= 1'b0;
    end else begin
      pready_o <= apb_setup_w;
    end
  end

  // Read data and error, decoded in the setup cycle
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prdata_o <= '0;
      pslverr_o <= 1'b0;
    end else begin
      pslverr_o <= 1'b0;
      prdata_o <= '0;
      if (apb_setup_w) begin
        unique case (paddr_i)
          REG_CTRL: begin
            prdata_o <= ctrl_q;
          end
          REG_STATUS: begin
            prdata_o <= {19'h0, state_q == MQRP_RUN, quad_q, cur_q_q, 5'h0};
          end
          REG_IRQ_STAT: begin
            prdata_o <= {28'h0, irq_stat_q};
          end
          REG_IRQ_MASK: begin
            prdata_o <= {28'h0, irq_mask_q};
          end
          REG_SEL: begin
            prdata_o <= {27'h0, wsel_q};
          end
          REG_WDATA: begin
            prdata_o <= '0;
          end
          default: begin
            pslverr_o <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule : mqrp_top

// File: testbench/mqrp_top_properties.sv
// Port checker for the read port select block
`timescale 1ns/10ps
module mqrp_top_properties
  import mqrp_pkg::*;
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire mqrp_req_s req_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic output_valid_flag_o,
  input wire logic almost_empty_flag_o,
  input wire logic packet_ready_flag_o,
  input wire mqrp_flag_s flags_o,
  input wire logic prog_done_out_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  sequence s_setup;
    psel_i && !penable_i;
  endsequence
  sequence s_done_wr;
    psel_i && penable_i && pwrite_i && pready_o && paddr_i == REG_CTRL && pwdata_i[CTRL_PROG_DONE];
  endsequence
  a_apb_answer: assert property (s_setup |=> pready_o) else $error("no answer in access cycle");
  a_ready_access: assert property (pready_o |-> psel_i && penable_i) else $error("pready outside access");
  a_unmapped_err: assert property (s_setup ##0 paddr_i > REG_WDATA |=> pslverr_o) else $error("no error");
  a_err_ready: assert property (pslverr_o |-> pready_o && prdata_o == 32'h0) else $error("bad error answer");
  a_prog_done: assert property (s_done_wr |-> ##[1:2] !prog_done_out_o) else $error("done flag stuck");
  a_sync_gap: assert property (flags_o.flag_cycle_sync |=> !flags_o.flag_cycle_sync [*3]) else $error("sync gap");
  a_flag_pair: assert property (packet_ready_flag_o |-> almost_empty_flag_o) else $error("flag levels");
  a_rdata_hold: assert property (output_valid_flag_o && !req_i.read_en && !req_i.queue_sel_strobe
    && !$past(req_i.queue_sel_strobe) |=> $stable(rdata_o)) else $error("data moved");
endmodule : mqrp_top_properties
bind mqrp_top mqrp_top_properties u_props (.clock_i(clock_i), .nrst_i(nrst_i), .req_i(req_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .rdata_o(rdata_o), .output_valid_flag_o(output_valid_flag_o),
  .almost_empty_flag_o(almost_empty_flag_o), .packet_ready_flag_o(packet_ready_flag_o), .flags_o(flags_o),
  .prog_done_out_o(prog_done_out_o));

// File: testbench/mqrp_ctrl_model.sv
// Read-side controller model driving the strobes
`timescale 1ns/10ps
module mqrp_ctrl_model
  import mqrp_pkg::*;
(
  input wire logic clock_i,
  input wire logic sel_i,
  input wire logic quad_i,
  input wire logic ren_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic prog_done_out_i,
  output mqrp_req_s req_o
);
  logic [ADDR_W-1:0] last_q = '0;
  initial req_o = '0;
  always @(posedge clock_i) begin
    if (sel_i || quad_i) last_q <= addr_i;
    req_o.queue_sel_strobe <= sel_i && !quad_i && !prog_done_out_i;
    req_o.flag_quad_strobe <= quad_i;
    req_o.read_en <= ren_i;
    // Released address shows inverse of last value
    req_o.read_addr_bus <= (sel_i || quad_i) ? addr_i : ~last_q;
  end
endmodule : mqrp_ctrl_model

// File: testbench/mqrp_top_bench.sv
// Self-checking bench for the read port select block
`timescale 1ns/10ps
module mqrp_top_bench;
  import mqrp_pkg::*;
  logic clock_i = 0;
  logic nrst_i = 0;
  logic sel = 0, quad = 0, ren = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] addr = 8'h00;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic err, pready, pslverr, ov, ae, pr, pdone, irq;
  logic [DATA_W-1:0] rdata;
  mqrp_req_s req;
  mqrp_flag_s flags;
  int mismatches = 0;
  int samples_checked = 0;
  mqrp_ctrl_model u_model (.clock_i(clock_i), .sel_i(sel), .quad_i(quad), .ren_i(ren), .addr_i(addr),
    .prog_done_out_i(pdone), .req_o(req));
  mqrp_top u_dut (.clock_i(clock_i), .nrst_i(nrst_i), .req_i(req), .expansion_in_i(1'b0), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .rdata_o(rdata), .output_valid_flag_o(ov), .almost_empty_flag_o(ae),
    .packet_ready_flag_o(pr), .flags_o(flags), .expansion_out_o(), .prog_done_out_o(pdone), .irq_o(irq));
  initial forever #5 clock_i = ~clock_i;
  task automatic check(input string name, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
    @(posedge clock_i);
    penable <= 1'b1;
    // Answer seen mid-cycle stands until the completing edge
    do begin
      @(negedge clock_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      mismatches++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    @(posedge clock_i);
    {psel, penable} <= 2'b00;
  endtask : apb
  // One-cycle controller request; returns just after the taking edge
  task automatic pulse(input logic s, input logic q, input logic r, input logic [7:0] a);
    int n;
    n = 0;
    @(posedge clock_i);
    {sel, quad, ren, addr} <= {s, q, r, a};
    @(posedge clock_i);
    {sel, quad, ren} <= 3'b000;
    do begin
      @(posedge clock_i);
      n++;
    end while ((req.queue_sel_strobe | req.flag_quad_strobe | req.read_en) !== 1'b1 && n < 8);
    if ((req.queue_sel_strobe | req.flag_quad_strobe | req.read_en) !== 1'b1) begin
      mismatches++;
      finish_test();
    end
    #1;
  endtask : pulse
  task automatic t_regs();
    check("done_rst", pdone, 1);
    check("ae_rst", ae, 1);
    apb(0, 12'h020, 0);
    check("unmapped_err", err, 1);
    apb(1, REG_CTRL, 32'h25);
    apb(0, REG_CTRL, 0);
    check("ctrl", rd, 36'h25);
    check("done", pdone, 0);
  endtask : t_regs
  task automatic t_queue();
    apb(1, REG_SEL, 5);
    for (int i = 1; i <= 3; i++) apb(1, REG_WDATA, 32'h11 * i);
    pulse(1, 0, 0, 8'h45);
    @(posedge clock_i);
    #1;
    check("first_word", rdata, 36'h11);
    check("valid", ov, 1);
    pulse(0, 0, 1, 8'h00);
    check("read_word", rdata, 36'h22);
    pulse(1, 0, 0, 8'h60);
    repeat (2) @(posedge clock_i);
    #1;
    check("other_dev", rdata, 36'h22);
  endtask : t_queue
  task automatic t_flag_irq();
    apb(1, REG_IRQ_MASK, 32'h2);
    pulse(0, 1, 0, 8'h41);
    repeat (2) @(posedge clock_i);
    #1;
    check("irq_set", irq, 1);
    apb(0, REG_STATUS, 0);
    check("quad_sel", rd[11:10], 2'h1);
    check("cur_queue", rd[9:5], 5'h05);
    check("ae_single", ae, 0);
    check("pr_single", pr, 0);
    check("pr_bus", flags.packet_ready_flag_bus, 8'hFF);
    apb(1, REG_IRQ_STAT, 32'h2);
    repeat (2) @(posedge clock_i);
    #1;
    check("irq_clr", irq, 0);
  endtask : t_flag_irq
  initial begin
    repeat (20) @(posedge clock_i);
    nrst_i <= 1'b1;
    t_regs();
    t_queue();
    t_flag_irq();
    finish_test();
  end
endmodule : mqrp_top_bench
